// ---- hdl/bld_led_cmd_top.sv ----
// Purpose: indicator grid command decoder with a register slave
// Assumes: the command port is synchronous to i_core_clk (25 MHz)
// Notes:   the port word is applied every cycle while enabled; repeats are harmless
//
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module bld_led_cmd_top
  import bld_pkg::*;
(
  // clock and reset
  input  wire logic                     i_core_clk,
  input  wire logic                     i_reset,
  // parallel command port from the processor
  input  wire logic [BLD_WORD_W-1:0]    i_cmd_word,
  // avalon-mm slave
  input  wire logic [BLD_AV_ADDR_W-1:0] i_avs_address,
  input  wire logic                     i_avs_read,
  input  wire logic                     i_avs_write,
  input  wire logic [BLD_AV_DATA_W-1:0] i_avs_writedata,
  input  wire logic [3:0]               i_avs_byteenable,
  output logic      [BLD_AV_DATA_W-1:0] o_avs_readdata,
  output logic                          o_avs_waitrequest,
  // indicator drive
  output logic      [BLD_NUM_LEDS-1:0]  o_leds
);

  typedef struct packed {
    bld_bus_state_t          bus;
    logic                    port_en;
    logic [BLD_WORD_W-1:0]   last_cmd;
    logic [BLD_WORD_W-1:0]   sw_word;
    logic                    sw_valid;
    logic                    sw_clr_all;
    logic [BLD_AV_DATA_W-1:0] rdata;
  } bld_top_state_t;

  bld_top_state_t          st_reg;
  bld_top_state_t          st_next;

  logic                    access;
  logic                    accept;
  logic [BLD_NUM_LEDS-1:0] leds;
  logic [BLD_NUM_LEDS-1:0] port_set;
  logic [BLD_NUM_LEDS-1:0] port_clr;
  logic                    port_all;
  logic [BLD_NUM_LEDS-1:0] sw_set;
  logic [BLD_NUM_LEDS-1:0] sw_clr;
  logic                    sw_all;
  logic                    port_act;

  // every access takes exactly one wait state, so read data is always a flop
  assign access            = i_avs_read | i_avs_write;
  assign accept            = access && (st_reg.bus == BLD_BUS_ACK);
  assign o_avs_waitrequest = access && (st_reg.bus != BLD_BUS_ACK);
  assign o_avs_readdata    = st_reg.rdata;
  assign port_act          = st_reg.port_en && (i_cmd_word[7:5] != 3'h0);

  // decoder for the processor port
  bld_cmd_decode u_port_dec (
    .i_word     (i_cmd_word),
    .i_valid    (st_reg.port_en),
    .o_set_mask (port_set),
    .o_clr_mask (port_clr),
    .o_clr_all  (port_all)
  );

  // decoder for commands written by software
  bld_cmd_decode u_sw_dec (
    .i_word     (st_reg.sw_word),
    .i_valid    (st_reg.sw_valid),
    .o_set_mask (sw_set),
    .o_clr_mask (sw_clr),
    .o_clr_all  (sw_all)
  );

  // both sources merge; a clear from either one beats a set from the other
  bld_led_grid u_grid (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_set_mask (port_set | sw_set),
    .i_clr_mask (port_clr | sw_clr),
    .i_clr_all  (port_all | sw_all | st_reg.sw_clr_all),
    .o_leds     (leds)
  );

  assign o_leds = leds;

  // bus handshake, register writes and read data capture
  always_comb begin
    st_next            = st_reg;
    st_next.sw_valid   = 1'b0;
    st_next.sw_clr_all = 1'b0;
    case (st_reg.bus)
      BLD_BUS_IDLE: begin
        if (access) begin
          st_next.bus = BLD_BUS_ACK;
        end
        if (i_avs_read) begin
          case (i_avs_address)
            BLD_REG_CTRL: st_next.rdata = {31'h0, st_reg.port_en};
            BLD_REG_CMD:  st_next.rdata = {24'h0, st_reg.last_cmd};
            BLD_REG_LEDS: st_next.rdata = leds;
            BLD_REG_PORT: st_next.rdata = {24'h0, i_cmd_word};
            default:      st_next.rdata = 32'h0000_0000;
          endcase
        end
      end
      BLD_BUS_ACK: begin
        st_next.bus = BLD_BUS_IDLE;
        if (accept && i_avs_write && i_avs_byteenable[0]) begin
          case (i_avs_address)
            BLD_REG_CTRL: begin
              st_next.port_en    = i_avs_writedata[BLD_CTRL_EN_BIT];
              st_next.sw_clr_all = i_avs_writedata[BLD_CTRL_CLR_BIT];
            end
            BLD_REG_CMD: begin
              st_next.sw_word  = i_avs_writedata[BLD_WORD_W-1:0];
              st_next.sw_valid = 1'b1;
            end
            default: begin
              st_next.sw_valid = 1'b0;                             // unmapped writes ignored
            end
          endcase
        end
      end
      default: begin
        st_next.bus = BLD_BUS_IDLE;
      end
    endcase
    // last applied command; software wins the record, not the effect
    if (st_reg.sw_valid) begin
      st_next.last_cmd = st_reg.sw_word;
    end else if (port_act) begin
      st_next.last_cmd = i_cmd_word;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      st_reg.bus        <= BLD_BUS_IDLE;
      st_reg.port_en    <= BLD_CTRL_EN_RST;
      st_reg.last_cmd   <= BLD_CMD_RST;
      st_reg.sw_word    <= BLD_CMD_RST;
      st_reg.sw_valid   <= 1'b0;
      st_reg.sw_clr_all <= 1'b0;
      st_reg.rdata      <= BLD_RDATA_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // helper signals for the checks below
  logic                    sw_busy;
  logic [BLD_NUM_LEDS-1:0] hit_port;
  logic [BLD_IDX_W-1:0]    hit_idx;
  logic [2:0]              act_bits;

  assign sw_busy  = st_reg.sw_valid | st_reg.sw_clr_all;
  assign hit_port = bld_led_onehot(i_cmd_word);
  assign act_bits = i_cmd_word[7:5];
  // column times four plus position, written out the long way on purpose
  assign hit_idx  = 5'(i_cmd_word[4:2]) * 5'h04 + 5'(i_cmd_word[1:0]);

  property p_on_sets;
    @(posedge i_core_clk) disable iff (i_reset)
      (st_reg.port_en && act_bits == 3'h1 && !sw_busy) |=> leds[$past(hit_idx)];
  endproperty
  a_on_sets: assert property (p_on_sets)
    else $error("on command did not light the addressed indicator");

  property p_index_map;
    @(posedge i_core_clk) disable iff (i_reset)
      (st_reg.port_en && act_bits == 3'h1 && !sw_busy && i_cmd_word[4:0] == 5'h1c)
        |=> leds[28];
  endproperty
  a_index_map: assert property (p_index_map)
    else $error("column 7 top did not map to grid bit 28");

  property p_off_clears;
    @(posedge i_core_clk) disable iff (i_reset)
      (st_reg.port_en && i_cmd_word[BLD_OFF_BIT]) |=> !leds[$past(hit_idx)];
  endproperty
  a_off_clears: assert property (p_off_clears)
    else $error("off command left the addressed indicator lit");

  property p_all_off;
    @(posedge i_core_clk) disable iff (i_reset)
      (st_reg.port_en && i_cmd_word[BLD_ALL_OFF_BIT]) |=> (leds == 32'h0000_0000);
  endproperty
  a_all_off: assert property (p_all_off)
    else $error("clear-all left an indicator lit");

  property p_hold;
    @(posedge i_core_clk) disable iff (i_reset)
      (!port_act && !sw_busy) |=> $stable(leds);
  endproperty
  a_hold: assert property (p_hold)
    else $error("indicator changed with no command");

  property p_isolated;
    @(posedge i_core_clk) disable iff (i_reset)
      (port_act && !sw_busy && !i_cmd_word[BLD_ALL_OFF_BIT])
        |=> ((leds & ~$past(hit_port)) == ($past(leds) & ~$past(hit_port)));
  endproperty
  a_isolated: assert property (p_isolated)
    else $error("single command touched another indicator");

  property p_null_word;
    @(posedge i_core_clk) disable iff (i_reset)
      (st_reg.port_en && act_bits == 3'h0 && !sw_busy) ##1 (act_bits == 3'h0 && !sw_busy)
        |=> $stable(leds);
  endproperty
  a_null_word: assert property (p_null_word)
    else $error("word without action bits changed the grid");

  property p_off_beats_on;
    @(posedge i_core_clk) disable iff (i_reset)
      (st_reg.port_en && act_bits == 3'h3) |=> !leds[$past(hit_idx)];
  endproperty
  a_off_beats_on: assert property (p_off_beats_on)
    else $error("on beat off in the same word");

  property p_bus_answer;
    @(posedge i_core_clk) disable iff (i_reset)
      (access && o_avs_waitrequest) |=> (!access || !o_avs_waitrequest);
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus access waited more than one cycle");

  property p_pos_left;
    @(posedge i_core_clk) disable iff (i_reset)
      (st_reg.port_en && act_bits == 3'h1 && !sw_busy && i_cmd_word[4:0] == 5'h05)
        |=> leds[5];
  endproperty
  a_pos_left: assert property (p_pos_left)
    else $error("column 1 left did not map to grid bit 5");

  property p_pos_bottom;
    @(posedge i_core_clk) disable iff (i_reset)
      (st_reg.port_en && act_bits == 3'h1 && !sw_busy && i_cmd_word[4:0] == 5'h03)
        |=> leds[3];
  endproperty
  a_pos_bottom: assert property (p_pos_bottom)
    else $error("column 0 bottom did not map to grid bit 3");

  property p_col_last;
    @(posedge i_core_clk) disable iff (i_reset)
      (st_reg.port_en && act_bits == 3'h1 && !sw_busy && i_cmd_word[4:0] == 5'h1f)
        |=> leds[31];
  endproperty
  a_col_last: assert property (p_col_last)
    else $error("column 7 bottom did not map to grid bit 31");

  property p_sw_clear_all;
    @(posedge i_core_clk) disable iff (i_reset)
      st_reg.sw_clr_all |=> (leds == 32'h0000_0000);
  endproperty
  a_sw_clear_all: assert property (p_sw_clear_all)
    else $error("software clear-all left an indicator lit");

  // the first edge after release must still show a dark grid
  property p_power_up;
    @(posedge i_core_clk) disable iff (i_reset)
      $fell(i_reset) |-> (leds == 32'h0000_0000);
  endproperty
  a_power_up: assert property (p_power_up)
    else $error("indicator lit straight after reset");

  property p_read_leds;
    @(posedge i_core_clk) disable iff (i_reset)
      (accept && i_avs_read && i_avs_address == BLD_REG_LEDS)
        |-> (o_avs_readdata == $past(leds));
  endproperty
  a_read_leds: assert property (p_read_leds)
    else $error("grid readback differs from stored state");

  // the clear-all control bit is a pulse and must never read back as set
  property p_ctrl_clr_reads_zero;
    @(posedge i_core_clk) disable iff (i_reset)
      (accept && i_avs_read && i_avs_address == BLD_REG_CTRL)
        |-> !o_avs_readdata[BLD_CTRL_CLR_BIT];
  endproperty
  a_ctrl_clr_reads_zero: assert property (p_ctrl_clr_reads_zero)
    else $error("clear-all control bit read back as set");

  c_on_then_off: cover property (@(posedge i_core_clk) disable iff (i_reset)
    (port_act && act_bits == 3'h1) ##[1:20] (port_act && act_bits == 3'h2));
  c_all_off: cover property (@(posedge i_core_clk) disable iff (i_reset)
    (leds != 32'h0000_0000) ##1 (port_act && act_bits == 3'h4));
  c_sw_cmd: cover property (@(posedge i_core_clk) disable iff (i_reset)
    st_reg.sw_valid ##1 (leds != 32'h0000_0000));
  c_read_leds: cover property (@(posedge i_core_clk) disable iff (i_reset)
    (accept && i_avs_read && i_avs_address == BLD_REG_LEDS));
  c_sw_clear: cover property (@(posedge i_core_clk) disable iff (i_reset)
    st_reg.sw_clr_all ##1 (leds == 32'h0000_0000));

endmodule : bld_led_cmd_top
`default_nettype wire

// ---- hdl/bld_pkg.sv ----
// Purpose: shared constants and types for the indicator grid command decoder
// Assumes: one 25 MHz clock, asynchronous active-high reset
// Notes:   every offset, field position and reset value is named once here
package bld_pkg;

  // command word layout
  localparam int unsigned BLD_WORD_W      = 8;
  localparam int unsigned BLD_POS_W       = 2;
  localparam int unsigned BLD_COL_W       = 3;
  localparam int unsigned BLD_IDX_W       = 5;
  localparam int unsigned BLD_NUM_LEDS    = 32;
  localparam int unsigned BLD_POS_LSB     = 0;
  localparam int unsigned BLD_COL_LSB     = 2;
  localparam int unsigned BLD_ON_BIT      = 5;
  localparam int unsigned BLD_OFF_BIT     = 6;
  localparam int unsigned BLD_ALL_OFF_BIT = 7;

  // position codes inside one column
  localparam logic [1:0] BLD_POS_TOP    = 2'h0;
  localparam logic [1:0] BLD_POS_LEFT   = 2'h1;
  localparam logic [1:0] BLD_POS_RIGHT  = 2'h2;
  localparam logic [1:0] BLD_POS_BOTTOM = 2'h3;

  // register bus
  localparam int unsigned BLD_AV_ADDR_W = 4;
  localparam int unsigned BLD_AV_DATA_W = 32;
  localparam logic [3:0]  BLD_REG_CTRL  = 4'h0;
  localparam logic [3:0]  BLD_REG_CMD   = 4'h4;
  localparam logic [3:0]  BLD_REG_LEDS  = 4'h8;
  localparam logic [3:0]  BLD_REG_PORT  = 4'hc;

  // control register fields and reset values
  localparam int unsigned BLD_CTRL_EN_BIT  = 0;
  localparam int unsigned BLD_CTRL_CLR_BIT = 1;
  localparam logic        BLD_CTRL_EN_RST  = 1'b1;
  localparam logic [7:0]  BLD_CMD_RST      = 8'h00;
  localparam logic [31:0] BLD_LEDS_RST     = 32'h0000_0000;
  localparam logic [31:0] BLD_RDATA_RST    = 32'h0000_0000;

  typedef enum logic [0:0] {
    BLD_BUS_IDLE = 1'b0,
    BLD_BUS_ACK  = 1'b1
  } bld_bus_state_t;

  // grid index of an addressed indicator: column times four plus position
  function automatic logic [BLD_IDX_W-1:0] bld_led_index(input logic [BLD_WORD_W-1:0] word);
    bld_led_index = {word[BLD_COL_LSB +: BLD_COL_W], word[BLD_POS_LSB +: BLD_POS_W]};
  endfunction : bld_led_index

  // one-hot mask of the addressed indicator
  function automatic logic [BLD_NUM_LEDS-1:0] bld_led_onehot(input logic [BLD_WORD_W-1:0] word);
    bld_led_onehot = 32'h0000_0001 << bld_led_index(word);
  endfunction : bld_led_onehot

endpackage : bld_pkg

// ---- hdl/bld_cmd_decode.sv ----
// Purpose: turns one command word into set, clear and clear-all requests
// Assumes: word is valid whenever i_valid is high
// Notes:   purely combinational, no state
`timescale 1ns/1ps
`default_nettype none
module bld_cmd_decode
  import bld_pkg::*;
(
  // command in
  input  wire logic [BLD_WORD_W-1:0]   i_word,
  input  wire logic                    i_valid,
  // decoded requests
  output logic      [BLD_NUM_LEDS-1:0] o_set_mask,
  output logic      [BLD_NUM_LEDS-1:0] o_clr_mask,
  output logic                         o_clr_all
);

  logic [BLD_NUM_LEDS-1:0] hit;

  // action bits act independently; priority is settled in the grid
  always_comb begin
    hit        = bld_led_onehot(i_word);
    o_set_mask = (i_valid && i_word[BLD_ON_BIT]) ? hit : '0;
    o_clr_mask = (i_valid && i_word[BLD_OFF_BIT]) ? hit : '0;
    o_clr_all  = i_valid && i_word[BLD_ALL_OFF_BIT];
  end

endmodule : bld_cmd_decode
`default_nettype wire

// ---- hdl/bld_led_grid.sv ----
// Purpose: latched storage for the 32 indicators of the grid
// Assumes: masks are requests in the core clock domain, applied on every cycle they stand
// Notes:   clear-all beats clear, clear beats set
`timescale 1ns/1ps
`default_nettype none
module bld_led_grid
  import bld_pkg::*;
(
  // clock and reset
  input  wire logic                    i_core_clk,
  input  wire logic                    i_reset,
  // requests
  input  wire logic [BLD_NUM_LEDS-1:0] i_set_mask,
  input  wire logic [BLD_NUM_LEDS-1:0] i_clr_mask,
  input  wire logic                    i_clr_all,
  // state
  output logic      [BLD_NUM_LEDS-1:0] o_leds
);

  typedef struct packed {
    logic [BLD_NUM_LEDS-1:0] leds;
  } bld_grid_state_t;

  bld_grid_state_t         st_reg;
  bld_grid_state_t         st_next;
  logic [BLD_NUM_LEDS-1:0] bit_next;

  // each indicator keeps its value unless its own request or a clear-all arrives
  for (genvar g = 0; g < BLD_NUM_LEDS; g++) begin : g_led
    assign bit_next[g] = i_clr_all     ? 1'b0 :
                         i_clr_mask[g] ? 1'b0 :
                         i_set_mask[g] ? 1'b1 : st_reg.leds[g];
  end

  always_comb begin
    st_next      = st_reg;
    st_next.leds = bit_next;
  end

  // power-up leaves every indicator dark
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      st_reg.leds <= BLD_LEDS_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_leds = st_reg.leds;

endmodule : bld_led_grid
`default_nettype wire

// ---- sim/bld_proc_model.sv ----
// Purpose: behavioural processor driving the parallel command word
// Assumes: fields change just after a core clock edge
// Notes:   word is address plus action value; codes 4 and 5 stack action bits on purpose
`timescale 1ns/1ps
`default_nettype none
module bld_proc_model
  import bld_pkg::*;
(
  // request from the bench
  input  wire logic [2:0]            i_col,
  input  wire logic [1:0]            i_pos,
  input  wire logic [2:0]            i_action,
  // digital output lines
  output logic      [BLD_WORD_W-1:0] o_cmd_word
);
  logic [7:0] action_value;

  // action code to action value; 4 and 5 exist only to probe priority
  always_comb begin
    case (i_action)
      3'h1:    action_value = 8'h20;
      3'h2:    action_value = 8'h40;
      3'h3:    action_value = 8'h80;
      3'h4:    action_value = 8'h60;
      3'h5:    action_value = 8'ha0;
      default: action_value = 8'h00;
    endcase
  end

  // address 0..31 is column times four plus position, action added on top
  assign o_cmd_word = 8'({i_col, i_pos}) + action_value;
endmodule : bld_proc_model
`default_nettype wire

// ---- sim/testbench.sv ----
// Purpose: self-checking bench for the indicator grid command decoder
// Assumes: 25 MHz core clock, one wait state on the register bus
// Notes:   expected grid built from column*4+position, never from the design
`timescale 1ns/1ps
`default_nettype none
module testbench
  import bld_pkg::*;
();
  logic        clk;
  logic        rst;
  logic [3:0]  av_addr;
  logic        av_rd;
  logic        av_wr;
  logic [31:0] av_wdata;
  logic [3:0]  av_be;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic [31:0] leds;
  logic [7:0]  cmd_word;
  logic [2:0]  p_col;
  logic [1:0]  p_pos;
  logic [2:0]  p_act;
  logic [31:0] exp_leds;
  logic [31:0] rd;
  int          errors;
  int          comparisons;
  int          cycles;

  bld_proc_model proc (.i_col(p_col), .i_pos(p_pos), .i_action(p_act), .o_cmd_word(cmd_word));

  bld_led_cmd_top uut (
    .i_core_clk(clk), .i_reset(rst), .i_cmd_word(cmd_word),
    .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
    .i_avs_writedata(av_wdata), .i_avs_byteenable(av_be),
    .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait), .o_leds(leds)
  );

  // 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  // one bus cycle; waitrequest and read data are taken at the accepting rising edge
  task automatic av_access(input logic wr, input logic [3:0] a, input logic [31:0] d,
                           input logic [3:0] be, output logic [31:0] q);
    @(posedge clk);
    av_addr  <= a;
    av_wdata <= d;
    av_be    <= be;
    if (wr) av_wr <= 1'b1;
    else av_rd <= 1'b1;
    @(posedge clk);
    while (av_wait !== 1'b0) @(posedge clk);
    q = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask : av_access

  // word stands two edges, then the action is dropped
  task automatic port_cmd(input logic [2:0] c, input logic [1:0] p, input logic [2:0] act);
    @(posedge clk);
    p_col <= c;
    p_pos <= p;
    p_act <= act;
    @(posedge clk);
    @(posedge clk);
    p_act <= 3'h0;
    #1;
  endtask : port_cmd

  // hang guard, generous against roughly 185 cycles of traffic
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    rst = 1'b1;
    av_addr = 4'h0;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_wdata = 32'h0;
    av_be = 4'h0;
    p_col = 3'h0;
    p_pos = 2'h0;
    p_act = 3'h0;
    errors = 0;
    comparisons = 0;
    cycles = 0;
    exp_leds = 32'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    check("leds after reset", leds, 32'h0);
    av_access(1'b0, BLD_REG_CTRL, 32'h0, 4'hf, rd);
    check("ctrl reset", rd, 32'h1);
    // light every indicator one at a time
    for (int c = 0; c < 8; c++) begin
      for (int p = 0; p < 4; p++) begin
        port_cmd(3'(c), 2'(p), 3'h1);
        exp_leds = exp_leds | (32'h1 << (c * 4 + p));
        check("leds set", leds, exp_leds);
      end
    end
    repeat (20) @(posedge clk);
    #1;
    check("leds held", leds, exp_leds);
    port_cmd(3'h7, 2'h0, 3'h2);
    check("leds off 28", leds, 32'hefff_ffff);
    port_cmd(3'h0, 2'h3, 3'h2);
    check("leds off 3", leds, 32'hefff_fff7);
    port_cmd(3'h7, 2'h0, 3'h4);
    check("on with off", leds, 32'hefff_fff7);
    port_cmd(3'h1, 2'h1, 3'h5);
    check("on with all off", leds, 32'h0);
    port_cmd(3'h4, 2'h2, 3'h3);
    check("all off idle", leds, 32'h0);
    // software commands over the bus
    av_access(1'b1, BLD_REG_CMD, 32'h25, 4'h1, rd);
    @(posedge clk);
    #1;
    check("sw on", leds, 32'h20);
    av_access(1'b1, BLD_REG_CMD, 32'h26, 4'h0, rd);
    repeat (2) @(posedge clk);
    #1;
    check("no byte lane", leds, 32'h20);
    av_access(1'b0, BLD_REG_LEDS, 32'h0, 4'hf, rd);
    check("leds reg", rd, 32'h20);
    av_access(1'b0, BLD_REG_CMD, 32'h0, 4'hf, rd);
    check("last cmd", rd, 32'h25);
    av_access(1'b0, BLD_REG_PORT, 32'h0, 4'hf, rd);
    check("port word", rd, 32'h12);
    av_access(1'b0, 4'h6, 32'h0, 4'hf, rd);
    check("unmapped read", rd, 32'h0);
    av_access(1'b1, BLD_REG_CTRL, 32'h0, 4'h1, rd);
    port_cmd(3'h2, 2'h2, 3'h1);
    check("port disabled", leds, 32'h20);
    av_access(1'b1, BLD_REG_CTRL, 32'h3, 4'h1, rd);
    @(posedge clk);
    #1;
    check("sw clear all", leds, 32'h0);
    av_access(1'b0, BLD_REG_CTRL, 32'h0, 4'hf, rd);
    check("ctrl readback", rd, 32'h1);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
